/* design/fvd_datapath_regs.sv */
/*
 * Register file and angle path of the vector control datapath.
 * Assumes an APB master on pclk and engine strobes synchronous to pclk.
 */
// Overview of operation
// - The final rotor angle is the observer angle plus the angle offset; a software write overrides it until the next recompute.
// - The d regulator output is clamped between its two limits.
// - The q regulator output is clamped between its two limits.
// - The d voltage command holds the d regulator result, read/write.
// - The q voltage command holds the q regulator result, read/write.
// - The next stage gets the d command plus the d voltage offset.
// - The next stage gets the q command plus the q voltage offset.
// - The d and q currents are readable, read only.
// - The stationary y current is readable, read only.
// - The stationary x and y voltages are readable, read only.
// - Phase A, B and C currents are readable, each read only.
// - Angles are signed 16 bit, full range spanning -180 to +180.
// - Observer angle reads the raw angle; a write loads a start angle.
// - The stationary x and y back-EMF values are readable, read only.
// - A set loop hold stops the regulator updating its command.
`timescale 1ns/10ps
module fvd_datapath_regs
    import fvd_pkg::*;
#(
    parameter int ADDR_W = 17
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Regulator results
    input wire logic d_pi_valid,
    input wire fvd_word_t d_pi_result,
    input wire logic q_pi_valid,
    input wire fvd_word_t q_pi_result,
    // Transform and sampling results
    input wire logic current_valid,
    input wire fvd_word_t d_current_in,
    input wire fvd_word_t q_current_in,
    input wire fvd_word_t stat_y_current_in,
    input wire fvd_word_t phase_a_in,
    input wire fvd_word_t phase_b_in,
    input wire fvd_word_t phase_c_in,
    input wire logic voltage_valid,
    input wire fvd_word_t stat_x_voltage_in,
    input wire fvd_word_t stat_y_voltage_in,
    // Observer results
    input wire logic observer_valid,
    input wire fvd_word_t observer_angle_in,
    input wire fvd_word_t stat_x_bemf_in,
    input wire fvd_word_t stat_y_bemf_in,
    // To the next stage and the observer
    output fvd_word_t d_voltage_out,
    output fvd_word_t q_voltage_out,
    output fvd_word_t rotor_angle_out,
    output logic observer_start_load,
    output fvd_word_t observer_start_angle
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic d_loop_hold;
    logic q_loop_hold;
    fvd_word_t angle_offset;
    fvd_word_t d_out_upper_limit;
    fvd_word_t d_out_lower_limit;
    fvd_word_t q_out_upper_limit;
    fvd_word_t q_out_lower_limit;
    fvd_word_t d_voltage_offset;
    fvd_word_t q_voltage_offset;
    fvd_word_t d_current_meas;
    fvd_word_t q_current_meas;
    fvd_word_t stat_y_current;
    fvd_word_t stat_x_voltage;
    fvd_word_t stat_y_voltage;
    fvd_word_t phase_a_current;
    fvd_word_t phase_b_current;
    fvd_word_t phase_c_current;
    fvd_word_t final_rotor_angle;
    fvd_word_t observer_angle;
    fvd_word_t stat_x_bemf;
    fvd_word_t stat_y_bemf;
    logic angle_dirty;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic [15:0] idx;
    logic [15:0] widx;
    logic low;
    logic addr_ok;
    logic wr_en;
    fvd_byte_t wbyte;
    fvd_word_t rd_word;

    assign idx = 16'(paddr[ADDR_W-1:2]);
    // Word index drops the byte select
    assign widx = {idx[15:1], 1'b0};
    assign low = idx[0];
    assign wbyte = pwdata[7:0];
    // Misaligned or out of window answers with an error
    assign addr_ok = (paddr[1:0] == 2'b00) &&
                     (((idx >= IDX_ANGLE_OFFSET) && (idx <= IDX_LAST)) ||
                      (idx == IDX_CTRL));
    // Writes take effect only at the completing edge
    assign wr_en = psel && penable && pready && pwrite && addr_ok;

    function automatic logic hit(logic [15:0] w);
        return wr_en && (widx == w);
    endfunction : hit

    // ************************************************************
    // Axis stages
    // ************************************************************
    fvd_axis_if d_ax ();
    fvd_axis_if q_ax ();

    assign d_ax.pi_result = d_pi_result;
    assign d_ax.pi_valid = d_pi_valid;
    assign d_ax.hold = d_loop_hold;
    assign d_ax.upper = d_out_upper_limit;
    assign d_ax.lower = d_out_lower_limit;
    assign d_ax.offset = d_voltage_offset;
    assign d_ax.wr_hi = wr_en && (widx == IDX_D_CMD) && !low;
    assign d_ax.wr_lo = wr_en && (widx == IDX_D_CMD) && low;
    assign d_ax.wbyte = wbyte;

    assign q_ax.pi_result = q_pi_result;
    assign q_ax.pi_valid = q_pi_valid;
    assign q_ax.hold = q_loop_hold;
    assign q_ax.upper = q_out_upper_limit;
    assign q_ax.lower = q_out_lower_limit;
    assign q_ax.offset = q_voltage_offset;
    assign q_ax.wr_hi = wr_en && (widx == IDX_Q_CMD) && !low;
    assign q_ax.wr_lo = wr_en && (widx == IDX_Q_CMD) && low;
    assign q_ax.wbyte = wbyte;

    fvd_axis_stage u_d_stage (
        .pclk(pclk),
        .presetn(presetn),
        .ax(d_ax.stage)
    );

    fvd_axis_stage u_q_stage (
        .pclk(pclk),
        .presetn(presetn),
        .ax(q_ax.stage)
    );

    // Stage sums come straight from the stage flops
    assign d_voltage_out = d_ax.sum;
    assign q_voltage_out = q_ax.sum;

    // ************************************************************
    // Loop hold control
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_loop_hold <= 1'b0;
            q_loop_hold <= 1'b0;
        end else if (wr_en && (idx == IDX_CTRL)) begin
            d_loop_hold <= pwdata[CTRL_D_HOLD_BIT];
            q_loop_hold <= pwdata[CTRL_Q_HOLD_BIT];
        end
    end

    // ************************************************************
    // Limits and offsets written by software
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_offset <= RST_WORD;
            d_out_upper_limit <= RST_WORD;
            d_out_lower_limit <= RST_WORD;
            q_out_upper_limit <= RST_WORD;
            q_out_lower_limit <= RST_WORD;
        end else if (hit(IDX_ANGLE_OFFSET)) begin
            angle_offset <= fvd_put_byte(angle_offset, low, wbyte);
        end else if (hit(IDX_D_UPPER)) begin
            d_out_upper_limit <= fvd_put_byte(d_out_upper_limit, low, wbyte);
        end else if (hit(IDX_D_LOWER)) begin
            d_out_lower_limit <= fvd_put_byte(d_out_lower_limit, low, wbyte);
        end else if (hit(IDX_Q_UPPER)) begin
            q_out_upper_limit <= fvd_put_byte(q_out_upper_limit, low, wbyte);
        end else if (hit(IDX_Q_LOWER)) begin
            q_out_lower_limit <= fvd_put_byte(q_out_lower_limit, low, wbyte);
        end
    end

    // Offsets sit behind the read-only voltage addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_voltage_offset <= RST_WORD;
            q_voltage_offset <= RST_WORD;
        end else if (hit(IDX_D_OFS)) begin
            d_voltage_offset <= fvd_put_byte(d_voltage_offset, low, wbyte);
        end else if (hit(IDX_Q_OFS)) begin
            q_voltage_offset <= fvd_put_byte(q_voltage_offset, low, wbyte);
        end
    end

    // ************************************************************
    // Read-only captures from the engine
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_current_meas <= RST_WORD;
            q_current_meas <= RST_WORD;
            stat_y_current <= RST_WORD;
            phase_a_current <= RST_WORD;
            phase_b_current <= RST_WORD;
            phase_c_current <= RST_WORD;
        end else if (current_valid) begin
            d_current_meas <= d_current_in;
            q_current_meas <= q_current_in;
            stat_y_current <= stat_y_current_in;
            phase_a_current <= phase_a_in;
            phase_b_current <= phase_b_in;
            phase_c_current <= phase_c_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_x_voltage <= RST_WORD;
            stat_y_voltage <= RST_WORD;
        end else if (voltage_valid) begin
            stat_x_voltage <= stat_x_voltage_in;
            stat_y_voltage <= stat_y_voltage_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_x_bemf <= RST_WORD;
            stat_y_bemf <= RST_WORD;
        end else if (observer_valid) begin
            stat_x_bemf <= stat_x_bemf_in;
            stat_y_bemf <= stat_y_bemf_in;
        end
    end

    // ************************************************************
    // Observer angle and start angle
    // ************************************************************
    // A software write wins over an observer update that cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            observer_angle <= RST_WORD;
        end else if (hit(IDX_OBS)) begin
            observer_angle <= fvd_put_byte(observer_angle, low, wbyte);
        end else if (observer_valid) begin
            observer_angle <= observer_angle_in;
        end
    end

    // Start angle goes out after the low byte completes the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            observer_start_load <= 1'b0;
            observer_start_angle <= RST_WORD;
        end else begin
            observer_start_load <= hit(IDX_OBS) && low;
            if (hit(IDX_OBS)) begin
                observer_start_angle <=
                    fvd_put_byte(observer_angle, low, wbyte);
            end
        end
    end

    // ************************************************************
    // Final rotor angle
    // ************************************************************
    // Recompute one cycle after any input changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_dirty <= 1'b0;
        end else begin
            angle_dirty <= observer_valid || hit(IDX_OBS) ||
                           hit(IDX_ANGLE_OFFSET);
        end
    end

    // Wraps modulo 2^16, so +180 rolls over to -180
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            final_rotor_angle <= RST_WORD;
        end else if (hit(IDX_ROTOR)) begin
            final_rotor_angle <= fvd_put_byte(final_rotor_angle, low, wbyte);
        end else if (angle_dirty) begin
            final_rotor_angle <= 16'(observer_angle + angle_offset);
        end
    end

    assign rotor_angle_out = final_rotor_angle;

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    function automatic fvd_word_t word_at(logic [15:0] w);
        if (w == IDX_ANGLE_OFFSET) begin
            return angle_offset;
        end else if (w == IDX_D_UPPER) begin
            return d_out_upper_limit;
        end else if (w == IDX_D_LOWER) begin
            return d_out_lower_limit;
        end else if (w == IDX_Q_UPPER) begin
            return q_out_upper_limit;
        end else if (w == IDX_Q_LOWER) begin
            return q_out_lower_limit;
        end else if (w == IDX_D_CMD) begin
            return d_ax.cmd;
        end else if (w == IDX_Q_CMD) begin
            return q_ax.cmd;
        end else if (w == IDX_D_CUR) begin
            return d_current_meas;
        end else if (w == IDX_Q_CUR) begin
            return q_current_meas;
        end else if (w == IDX_Y_CUR) begin
            return stat_y_current;
        end else if (w == IDX_Y_VOLT) begin
            return stat_y_voltage;
        end else if (w == IDX_X_VOLT) begin
            return stat_x_voltage;
        end else if (w == IDX_C_CUR) begin
            return phase_c_current;
        end else if (w == IDX_B_CUR) begin
            return phase_b_current;
        end else if (w == IDX_A_CUR) begin
            return phase_a_current;
        end else if (w == IDX_ROTOR) begin
            return final_rotor_angle;
        end else if (w == IDX_OBS) begin
            return observer_angle;
        end else if (w == IDX_X_BEMF) begin
            return stat_x_bemf;
        end else if (w == IDX_Y_BEMF) begin
            return stat_y_bemf;
        end
        return RST_WORD;
    endfunction : word_at

    // Process form so register changes re-run the lookup
    always_comb rd_word = word_at(widx);

    // ************************************************************
    // APB answer
    // ************************************************************
    // No wait state: data is fetched in setup so prdata is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            if (!addr_ok || pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (idx == IDX_CTRL) begin
                prdata <= {30'h0000_0000, q_loop_hold, d_loop_hold};
            end else if (low) begin
                prdata <= {24'h00_0000, rd_word[7:0]};
            end else begin
                prdata <= {24'h00_0000, rd_word[15:8]};
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : fvd_datapath_regs

/* design/fvd_pkg.sv */
/*
 * Constants, types and shared arithmetic of the vector datapath.
 * Assumes a byte-wide register view mapped onto APB words.
 */
package fvd_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic signed [15:0] fvd_word_t;
    typedef logic [7:0] fvd_byte_t;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [15:0] IDX_CTRL = 16'h40A1;
    localparam logic [15:0] IDX_ANGLE_OFFSET = 16'h40AE;
    localparam logic [15:0] IDX_D_UPPER = 16'h40B0;
    localparam logic [15:0] IDX_D_LOWER = 16'h40B2;
    localparam logic [15:0] IDX_Q_UPPER = 16'h40B4;
    localparam logic [15:0] IDX_Q_LOWER = 16'h40B6;
    localparam logic [15:0] IDX_D_CMD = 16'h40B8;
    localparam logic [15:0] IDX_Q_CMD = 16'h40BA;
    localparam logic [15:0] IDX_D_CUR = 16'h40BC;
    localparam logic [15:0] IDX_Q_CUR = 16'h40BE;
    localparam logic [15:0] IDX_Y_CUR = 16'h40C0;
    localparam logic [15:0] IDX_Y_VOLT = 16'h40C2;
    localparam logic [15:0] IDX_D_OFS = 16'h40C2;
    localparam logic [15:0] IDX_X_VOLT = 16'h40C4;
    localparam logic [15:0] IDX_Q_OFS = 16'h40C4;
    localparam logic [15:0] IDX_C_CUR = 16'h40C6;
    localparam logic [15:0] IDX_B_CUR = 16'h40C8;
    localparam logic [15:0] IDX_A_CUR = 16'h40CA;
    localparam logic [15:0] IDX_ROTOR = 16'h40CC;
    localparam logic [15:0] IDX_OBS = 16'h40CE;
    localparam logic [15:0] IDX_X_BEMF = 16'h40D0;
    localparam logic [15:0] IDX_Y_BEMF = 16'h40D2;
    localparam logic [15:0] IDX_LAST = 16'h40D3;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_D_HOLD_BIT = 0;
    localparam int CTRL_Q_HOLD_BIT = 1;
    localparam fvd_word_t RST_WORD = 16'sh0000;
    localparam fvd_byte_t RST_BYTE = 8'h00;

    // ************************************************************
    // Shared arithmetic
    // ************************************************************
    // Saturating signed add, keeps the voltage from wrapping
    function automatic fvd_word_t fvd_sat_add(fvd_word_t a, fvd_word_t b);
        logic signed [16:0] s;
        s = 17'(a) + 17'(b);
        if (s > 17'sh0_7FFF) begin
            return 16'sh7FFF;
        end else if (s < -17'sh0_8000) begin
            return -16'sh8000;
        end
        return s[15:0];
    endfunction : fvd_sat_add

    // Upper limit is checked first if limits cross
    function automatic fvd_word_t fvd_clamp(fvd_word_t v, fvd_word_t hi,
                                            fvd_word_t lo);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction : fvd_clamp

    // Replace one byte of a word; high byte sits at the even index
    function automatic fvd_word_t fvd_put_byte(fvd_word_t w, logic low,
                                               fvd_byte_t b);
        return low ? {w[15:8], b} : {b, w[7:0]};
    endfunction : fvd_put_byte

endpackage : fvd_pkg

/* design/fvd_axis_if.sv */
/*
 * Bundle between the register file and one axis regulator stage.
 * Assumes both ends sit in the pclk domain.
 */
`timescale 1ns/10ps
interface fvd_axis_if;
    import fvd_pkg::*;
    fvd_word_t pi_result;
    logic pi_valid;
    logic hold;
    fvd_word_t upper;
    fvd_word_t lower;
    fvd_word_t offset;
    logic wr_hi;
    logic wr_lo;
    fvd_byte_t wbyte;
    fvd_word_t cmd;
    fvd_word_t sum;

    modport regs (
        output pi_result, pi_valid, hold, upper, lower, offset,
        output wr_hi, wr_lo, wbyte,
        input cmd, sum
    );
    modport stage (
        input pi_result, pi_valid, hold, upper, lower, offset,
        input wr_hi, wr_lo, wbyte,
        output cmd, sum
    );
endinterface : fvd_axis_if

/* design/fvd_axis_stage.sv */
/*
 * One axis of the regulator back end: clamp, command hold, offset add.
 * Assumes register writes and regulator strobes are pclk synchronous.
 */
`timescale 1ns/10ps
module fvd_axis_stage
    import fvd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the register file
    fvd_axis_if.stage ax
);

    // ************************************************************
    // Voltage command
    // ************************************************************
    // Software write wins over a regulator update in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ax.cmd <= RST_WORD;
        end else if (ax.wr_hi || ax.wr_lo) begin
            ax.cmd <= fvd_put_byte(ax.cmd, ax.wr_lo, ax.wbyte);
        end else if (ax.pi_valid && !ax.hold) begin
            // Clamped result lands in the command
            ax.cmd <= fvd_clamp(ax.pi_result, ax.upper, ax.lower);
        end
    end

    // ************************************************************
    // Output to the next stage
    // ************************************************************
    // Saturated so a large offset cannot wrap the sum past full scale and flip its sign
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ax.sum <= RST_WORD;
        end else begin
            ax.sum <= fvd_sat_add(ax.cmd, ax.offset);
        end
    end

endmodule : fvd_axis_stage

/* verification/fvd_regs_sva.sv */
/* Checker for the vector datapath register block.
   Assumes it is bound onto fvd_datapath_regs and sees its ports only. */
`timescale 1ns/10ps
module fvd_regs_sva
    import fvd_pkg::*;
#(
    parameter int ADDR_W = 17
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Engine side
    input wire logic q_pi_valid,
    input wire logic observer_valid,
    input wire fvd_word_t q_voltage_out,
    input wire fvd_word_t rotor_angle_out,
    input wire logic observer_start_load,
    input wire fvd_word_t observer_start_angle
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************
    // Sequences
    // ****************
    // Low byte write of the observer start angle
    sequence obs_wr_s;
        psel && penable && pready && pwrite &&
            paddr == ADDR_W'({IDX_OBS + 16'h0001, 2'b00});
    endsequence
    // No bus traffic and no q regulator strobe, or no observer strobe, for three cycles
    sequence quiet_q_s;
        (!psel && !q_pi_valid) [*3];
    endsequence
    sequence quiet_a_s;
        (!psel && !observer_valid) [*3];
    endsequence

    // ****************
    // Properties
    // ****************
    pready_one_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 0)
        else $error("read data above the byte lane");
    err_data_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("error response malformed");
    obs_load_a: assert property (obs_wr_s |=> observer_start_load)
        else $error("start angle load pulse missing");
    start_byte_a: assert property (obs_wr_s |=>
        observer_start_angle[7:0] == $past(pwdata[7:0]))
        else $error("start angle low byte wrong");
    volt_hold_a: assert property (quiet_q_s |-> $stable(q_voltage_out))
        else $error("q output moved without cause");
    angle_hold_a: assert property (quiet_a_s |->
        $stable(rotor_angle_out))
        else $error("rotor angle moved without cause");
endmodule : fvd_regs_sva

bind fvd_datapath_regs fvd_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .q_pi_valid, .observer_valid, .q_voltage_out,
    .rotor_angle_out, .observer_start_load, .observer_start_angle
);

/* verification/fvd_datapath_regs_tb.sv */
/* Self-checking bench for the vector datapath register block.
   Assumes the checker file binds itself onto the design. */
`timescale 1ns/10ps
module foc_vector_datapath_regs_tb;
    import fvd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ld, se;
    logic dv, qv, cv, vv, ov;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] rb;
    logic [15:0] cap [11];
    fvd_word_t dr, qr, w, dout, qout, rot, osa;
    int err_count, n_checks, i;

    fvd_datapath_regs dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .d_pi_valid(dv), .d_pi_result(dr),
        .q_pi_valid(qv), .q_pi_result(qr), .current_valid(cv),
        .d_current_in(w ^ 16'h0001), .q_current_in(w ^ 16'h0002),
        .stat_y_current_in(w ^ 16'h0003), .phase_a_in(w ^ 16'h0004),
        .phase_b_in(w ^ 16'h0005), .phase_c_in(w ^ 16'h0006),
        .voltage_valid(vv), .stat_x_voltage_in(w ^ 16'h0007),
        .stat_y_voltage_in(w ^ 16'h0008), .observer_valid(ov),
        .observer_angle_in(w ^ 16'h0009), .stat_x_bemf_in(w ^ 16'h000A),
        .stat_y_bemf_in(w ^ 16'h000B), .d_voltage_out(dout),
        .q_voltage_out(qout), .rotor_angle_out(rot),
        .observer_start_load(ld), .observer_start_angle(osa)
    );

    // ****************
    // Clock
    // ****************
    // 10 MHz
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // One APB byte transfer; bounded wait for pready
    task automatic apb(input logic wr, input logic [15:0] ix,
                       input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix[14:0], 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rb = prdata[7:0];
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_count++;
            give_verdict();
        end
    endtask : apb

    // High byte lives at the lower index
    task automatic wr16(input logic [15:0] ix, input logic [15:0] v);
        apb(1'b1, ix, v[15:8]);
        apb(1'b1, ix + 16'h0001, v[7:0]);
    endtask : wr16

    task automatic rc(input logic [15:0] ix, input logic [15:0] e);
        logic [7:0] h;
        apb(1'b0, ix, 8'h00);
        h = rb;
        apb(1'b0, ix + 16'h0001, 8'h00);
        chk($sformatf("reg %h", ix), e, {h, rb});
    endtask : rc

    // Both regulators strobe together
    task automatic pi(input fvd_word_t a, input fvd_word_t b);
        @(posedge pclk);
        dr <= a;
        qr <= b;
        dv <= 1'b1;
        qv <= 1'b1;
        @(posedge pclk);
        dv <= 1'b0;
        qv <= 1'b0;
    endtask : pi

    task automatic give_verdict();
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // ****************
    // Main sequence
    // ****************
    initial begin
        {presetn, psel, penable, pwrite, dv, qv, cv, vv, ov} = '0;
        {paddr, pwdata, dr, qr, w} = '0;
        cap = '{IDX_D_CUR, IDX_Q_CUR, IDX_Y_CUR, IDX_A_CUR, IDX_B_CUR,
            IDX_C_CUR, IDX_X_VOLT, IDX_Y_VOLT, IDX_OBS, IDX_X_BEMF,
            IDX_Y_BEMF};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 19; i++) begin
            rc(IDX_ANGLE_OFFSET + 16'(2 * i), 16'h0000);
        end
        // Read/write words hold both bytes independently
        for (i = 0; i < 7; i++) begin
            wr16(IDX_ANGLE_OFFSET + 16'(2 * i), 16'hA55A ^ 16'(i));
            rc(IDX_ANGLE_OFFSET + 16'(2 * i), 16'hA55A ^ 16'(i));
        end
        wr16(IDX_D_CUR, 16'h1234);
        rc(IDX_D_CUR, 16'h0000);
        wr16(IDX_D_UPPER, 16'h0064);
        wr16(IDX_D_LOWER, 16'hFF9C);
        wr16(IDX_Q_UPPER, 16'h0200);
        wr16(IDX_Q_LOWER, 16'hFE00);
        pi(16'sh01F4, -16'sh8000);
        rc(IDX_D_CMD, 16'h0064);
        rc(IDX_Q_CMD, 16'hFE00);
        pi(-16'sh01F4, 16'sh01FF);
        rc(IDX_D_CMD, 16'hFF9C);
        rc(IDX_Q_CMD, 16'h01FF);
        // Offsets share addresses with the voltage readings
        wr16(IDX_D_OFS, 16'h0005);
        wr16(IDX_Q_OFS, 16'hFFFF);
        repeat (3) @(posedge pclk);
        chk("d_out", 16'hFFA1, dout);
        chk("q_out", 16'h01FE, qout);
        rc(IDX_Y_VOLT, 16'h0000);
        wr16(IDX_D_OFS, 16'h8000);
        repeat (3) @(posedge pclk);
        chk("d_sat", 16'h8000, dout);
        apb(1'b1, IDX_CTRL, 8'h03);
        pi(16'sh0000, 16'sh0000);
        rc(IDX_D_CMD, 16'hFF9C);
        rc(IDX_Q_CMD, 16'h01FF);
        apb(1'b1, IDX_CTRL, 8'h00);
        pi(16'sh0030, 16'sh0040);
        rc(IDX_D_CMD, 16'h0030);
        // Capture every engine result in one strobe
        @(posedge pclk);
        w <= 16'h7E10;
        {cv, vv, ov} <= 3'b111;
        @(posedge pclk);
        {cv, vv, ov} <= 3'b000;
        for (i = 0; i < 11; i++) begin
            rc(cap[i], 16'h7E10 ^ 16'(i + 1));
        end
        wr16(IDX_ANGLE_OFFSET, 16'h1000);
        repeat (3) @(posedge pclk);
        chk("rotor", 16'h8E19, rot);
        rc(IDX_ROTOR, 16'h8E19);
        wr16(IDX_OBS, 16'hC000);
        repeat (3) @(posedge pclk);
        chk("start", 16'hC000, osa);
        rc(IDX_ROTOR, 16'hD000);
        apb(1'b0, IDX_LAST + 16'h0001, 8'h00);
        chk("slverr", 16'h0001, {15'h0000, se});
        give_verdict();
    end
endmodule : foc_vector_datapath_regs_tb
